/* File: sim/board_reset_model.sv */
// board model: cold reset pin, boot vector and warm reset wire
`default_nettype none
module board_reset_model
(
    input wire logic ref_clk_i,
    input wire logic cold_req_i,
    input wire logic warm_req_i,
    input wire logic [reset_seq_pkg::ADDR_LO_W-1:0] vector_i,
    input wire logic [reset_seq_pkg::ADDR_LO_W-1:0] dev_addr_i,
    input wire logic dev_addr_oe_n_i,
    input wire logic dev_warm_oe_n_i,
    output logic cold_reset_n_o,
    output logic vector_select_o,
    output logic [reset_seq_pkg::ADDR_LO_W-1:0] addr_wire_o,
    output logic warm_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import reset_seq_pkg::*;
    // ------------------------------
    // wire resolution
    // ------------------------------
    logic [ADDR_LO_W-1:0] last_addr;
    assign cold_reset_n_o = !cold_req_i;
    assign vector_select_o = 1'b1;
    // pull-up on the line; either side may pull it low, board lets go last
    assign warm_wire_o = !(warm_req_i || !dev_warm_oe_n_i);
    // vector only while cold reset is held; a floated bus toggles, never holds
    assign addr_wire_o = !dev_addr_oe_n_i ? dev_addr_i : cold_req_i ? vector_i : ~last_addr;
    always_ff @(posedge ref_clk_i) last_addr <= addr_wire_o;
endmodule
`default_nettype wire

/* File: sim/cold_warm_reset_sequencer_checker.sv */
// assertion checker for the cold and warm reset sequencer
`default_nettype none
module cold_warm_reset_sequencer_checker
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic cold_reset_n_in_i,
    input wire logic pll_locked_i,
    input wire logic warm_reset_n_io_i,
    input wire logic mem_periph_addr_lo_oe_n_o,
    input wire logic warm_reset_n_io_oe_n_o,
    input wire logic mem_periph_data_oe_n_o,
    input wire logic mem_ctrl_enable_o,
    input wire logic chip_select_enable_o,
    input wire logic ext_bus_clock_en_o,
    input wire logic reset_exception_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------
    // span counters
    // ------------------------------
    logic [11:0] hold_cnt;
    logic [11:0] rel_cnt;
    // saturating, so a long wait never wraps under the limit
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i) hold_cnt <= 12'h000;
        else hold_cnt <= (warm_reset_n_io_oe_n_o || !ext_bus_clock_en_o) ? 12'h000
            : hold_cnt + {11'h000, hold_cnt != 12'hFFF};
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i) rel_cnt <= 12'h000;
        else rel_cnt <= !warm_reset_n_io_oe_n_o ? 12'h000 : rel_cnt + {11'h000, rel_cnt != 12'hFFF};
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_float; !cold_reset_n_in_i |-> mem_periph_addr_lo_oe_n_o; endproperty
    a_float: assert property (p_float) else $error("low address driven");
    property p_cold_line; !cold_reset_n_in_i [*3] |-> !warm_reset_n_io_oe_n_o; endproperty
    a_cold_line: assert property (p_cold_line) else $error("line not driven");
    property p_resume; $rose(cold_reset_n_in_i) |-> ##[1:16] !mem_periph_addr_lo_oe_n_o; endproperty
    a_resume: assert property (p_resume) else $error("address drive late");
    property p_bus_clk; $rose(ext_bus_clock_en_o) |-> $past(pll_locked_i); endproperty
    a_bus_clk: assert property (p_bus_clk) else $error("bus clock early");
    // one cycle of slack for where the count starts
    property p_hold; $rose(warm_reset_n_io_oe_n_o) |-> hold_cnt >= 12'hF9F; endproperty
    a_hold: assert property (p_hold) else $error("line held short");
    property p_sample; reset_exception_o |-> rel_cnt >= 12'hF9F; endproperty
    a_sample: assert property (p_sample) else $error("sampled early");
    property p_data; $fell(mem_periph_data_oe_n_o) |-> rel_cnt >= 12'hF9F; endproperty
    a_data: assert property (p_data) else $error("data drive early");
    property p_warm; $fell(warm_reset_n_io_i) && !mem_periph_data_oe_n_o |-> ##[1:6]
        (mem_periph_data_oe_n_o && !mem_ctrl_enable_o && !chip_select_enable_o
        && !warm_reset_n_io_oe_n_o); endproperty
    a_warm: assert property (p_warm) else $error("warm entry wrong");
endmodule
bind cold_warm_reset_sequencer cold_warm_reset_sequencer_checker u_cold_warm_reset_sequencer_checker (.*);
`default_nettype wire

/* File: sim/cold_warm_reset_sequencer_tb_top.sv */
// self-checking testbench for the reset sequencer
`default_nettype none
module cold_warm_reset_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_seq_pkg::*;
    // ------------------------------
    // bench
    // ------------------------------
    logic ref_clk = 1'b0;
    logic pclk = 1'b0;
    logic nrst, cold_req, warm_req, pll_locked, nvram_done, cold_n, vec_sel, warm_wire;
    logic addr_oe_n, warm_drv, warm_oe_n, data_oe_n, ctrl_en, cs_en, bclk_en, internal_bus_clock, rst_exc, soft_exc;
    logic [ADDR_LO_W-1:0] addr_wire, addr_out, boot_vec;
    logic [ADDR_HI_W-1:0] addr_hi;
    logic [PCLK_SEL_W-1:0] pclk_sel;
    int fail_count = 0;
    int samples_checked = 0;
    int n;
    always #2 ref_clk = ~ref_clk;
    always #1.5 pclk = ~pclk;
    cold_warm_reset_sequencer u_cold_warm_reset_sequencer (.ref_clk_i(ref_clk), .nrst_i(nrst),
        .pclk_i(pclk), .cold_reset_n_in_i(cold_n), .external_vector_select_i(vec_sel),
        .mem_periph_addr_lo_i(addr_wire), .internal_vector_i(16'h0000), .warm_reset_n_io_i(warm_wire),
        .pll_locked_i(pll_locked), .nvram_init_done_i(nvram_done), .addr_hi_req_i(6'h2A),
        .addr_lo_req_i(16'h1234), .mem_periph_addr_lo_o(addr_out), .mem_periph_addr_lo_oe_n_o(addr_oe_n),
        .mem_periph_addr_hi_o(addr_hi), .warm_reset_n_io_o(warm_drv), .warm_reset_n_io_oe_n_o(warm_oe_n),
        .mem_periph_data_oe_n_o(data_oe_n), .mem_ctrl_enable_o(ctrl_en), .chip_select_enable_o(cs_en),
        .ext_bus_clock_en_o(bclk_en), .internal_bus_clock_o(internal_bus_clock), .boot_vector_o(boot_vec),
        .pclk_select_o(pclk_sel), .reset_exception_o(rst_exc), .soft_reset_exception_o(soft_exc));
    board_reset_model u_board_reset_model (.ref_clk_i(ref_clk), .cold_req_i(cold_req),
        .warm_req_i(warm_req), .vector_i(16'hA5C3), .dev_addr_i(addr_out), .dev_addr_oe_n_i(addr_oe_n),
        .dev_warm_oe_n_i(warm_oe_n), .cold_reset_n_o(cold_n), .vector_select_o(vec_sel),
        .addr_wire_o(addr_wire), .warm_wire_o(warm_wire));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // vector is held steady and dropped with the pin, so a late sample sees junk
    task automatic test_cold();
        logic b;
        @(posedge pclk);
        #0.5 b = internal_bus_clock;
        @(posedge pclk);
        #0.5 check("internal_bus_clock", internal_bus_clock, !b);
        repeat (20) @(negedge ref_clk);
        check("addr lo oe_n", addr_oe_n, 1'b1);
        check("line oe_n", warm_oe_n, 1'b0);
        check("line level", warm_drv, 1'b0);
        check("addr hi", addr_hi, 6'h2A);
        cold_req = 1'b0;
        repeat (16) @(negedge ref_clk);
        check("addr lo oe_n", addr_oe_n, 1'b0);
        pll_locked = 1'b1;
        repeat (20) @(negedge ref_clk);
        check("bus clock", bclk_en, 1'b0);
        nvram_done = 1'b1;
        for (n = 0; n < 20 && !bclk_en; n++) @(negedge ref_clk);
        check("bus clock", bclk_en, 1'b1);
        for (n = 0; n < 4100 && !warm_oe_n; n++) @(negedge ref_clk);
        check("hold span", n > 3997 && n < 4002, 1'b1);
        for (n = 0; n < 4100 && !rst_exc; n++) @(negedge ref_clk);
        check("sample span", n > 3996 && n < 4090, 1'b1);
        check("boot vector", boot_vec, 16'hA5C3);
        check("pclk select", pclk_sel, 3'h3);
        repeat (2) @(negedge ref_clk);
        check("data oe_n", data_oe_n, 1'b0);
    endtask
    task automatic test_warm();
        logic soft_seen;
        soft_seen = 1'b0;
        warm_req = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("data oe_n", data_oe_n, 1'b1);
        check("ctrl enable", ctrl_en, 1'b0);
        check("line oe_n", warm_oe_n, 1'b0);
        check("addr lo", addr_oe_n ? 16'hFFFF : addr_out, 16'h1234);
        for (n = 0; n < 4100 && !warm_oe_n; n++) @(negedge ref_clk);
        check("warm hold", n > 3985 && n < 4001, 1'b1);
        warm_req = 1'b0;
        for (n = 0; n < 4200 && !cs_en; n++)
        begin
            soft_seen = soft_seen | soft_exc;
            @(negedge ref_clk);
        end
        soft_seen = soft_seen | soft_exc;
        check("cs delay", n > 4015 && n < 4150, 1'b1);
        check("soft exception", soft_seen, 1'b1);
        check("data oe_n", data_oe_n, 1'b0);
    endtask
    initial
    begin
        nrst = 1'b0;
        cold_req = 1'b1;
        warm_req = 1'b0;
        pll_locked = 1'b0;
        nvram_done = 1'b0;
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        test_cold();
        test_warm();
        finish_test();
    end
    // both sequences need about 16000 cycles
    initial
    begin
        repeat (25000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire

/* File: src/cold_warm_reset_sequencer.sv */
// cold and warm reset sequencer with boot vector latch
`default_nettype none
module cold_warm_reset_sequencer
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic pclk_i,
    input wire logic cold_reset_n_in_i,
    input wire logic external_vector_select_i,
    input wire logic [reset_seq_pkg::ADDR_LO_W-1:0] mem_periph_addr_lo_i,
    input wire logic [reset_seq_pkg::ADDR_LO_W-1:0] internal_vector_i,
    input wire logic warm_reset_n_io_i,
    input wire logic pll_locked_i,
    input wire logic nvram_init_done_i,
    input wire logic [reset_seq_pkg::ADDR_HI_W-1:0] addr_hi_req_i,
    input wire logic [reset_seq_pkg::ADDR_LO_W-1:0] addr_lo_req_i,
    output logic [reset_seq_pkg::ADDR_LO_W-1:0] mem_periph_addr_lo_o,
    output logic mem_periph_addr_lo_oe_n_o,
    output logic [reset_seq_pkg::ADDR_HI_W-1:0] mem_periph_addr_hi_o,
    output logic warm_reset_n_io_o,
    output logic warm_reset_n_io_oe_n_o,
    output logic mem_periph_data_oe_n_o,
    output logic mem_ctrl_enable_o,
    output logic chip_select_enable_o,
    output logic ext_bus_clock_en_o,
    output logic internal_bus_clock_o,
    output logic [reset_seq_pkg::ADDR_LO_W-1:0] boot_vector_o,
    output logic [reset_seq_pkg::PCLK_SEL_W-1:0] pclk_select_o,
    output logic reset_exception_o,
    output logic soft_reset_exception_o
);
    import reset_seq_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic cold_meta;
    logic cold_n;
    logic warm_meta;
    logic warm_n;
    logic sel_meta;
    logic sel_sync;
    logic [ADDR_LO_W-1:0] vec_meta;
    logic [ADDR_LO_W-1:0] vec_sync;
    logic [ADDR_LO_W-1:0] vec_old;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cold_meta <= 1'b0;
            cold_n <= 1'b0;
            warm_meta <= 1'b0;
            warm_n <= 1'b0;
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
            vec_meta <= ADDR_LO_RESET;
            vec_sync <= ADDR_LO_RESET;
            vec_old <= ADDR_LO_RESET;
        end
        else
        begin
            cold_meta <= cold_reset_n_in_i;
            cold_n <= cold_meta;
            warm_meta <= warm_reset_n_io_i;
            warm_n <= warm_meta;
            sel_meta <= external_vector_select_i;
            sel_sync <= sel_meta;
            vec_meta <= mem_periph_addr_lo_i;
            vec_sync <= vec_meta;
            vec_old <= vec_sync;
        end
    end

    // ----------------------------------------------------------------
    // boot vector latch
    // ----------------------------------------------------------------
    // last load is two edges after the pin rises; vec_old then holds
    // the pin as it stood two edges before that release
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            boot_vector_o <= ADDR_LO_RESET;
            pclk_select_o <= '0;
        end
        else if (!cold_n)
        begin
            boot_vector_o <= sel_sync ? vec_old : internal_vector_i;
            pclk_select_o <= sel_sync ? vec_old[PCLK_SEL_LSB +: PCLK_SEL_W]
                : internal_vector_i[PCLK_SEL_LSB +: PCLK_SEL_W];
        end
    end

    // ----------------------------------------------------------------
    // internal bus clock, half the pipeline clock
    // ----------------------------------------------------------------
    always_ff @(posedge pclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            internal_bus_clock_o <= 1'b0;
        end
        else
        begin
            internal_bus_clock_o <= !internal_bus_clock_o;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    seq_state_t state;
    logic [CNT_BITS-1:0] cnt;
    logic [PLL_CNT_BITS-1:0] pll_cnt;
    logic pll_ok;
    logic nvram_ok;
    logic [4:0] drive_cnt;

    assign pll_ok = sel_sync ? pll_locked_i : (&pll_cnt);
    assign nvram_ok = boot_vector_o[NVRAM_DIS_BIT] || nvram_init_done_i;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pll_cnt <= '0;
        end
        else if (!cold_n)
        begin
            pll_cnt <= '0;
        end
        else if (!(&pll_cnt))
        begin
            pll_cnt <= pll_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= ST_COLD;
            cnt <= '0;
        end
        else if (!cold_n)
        begin
            state <= ST_COLD;
            cnt <= '0;
        end
        else
        begin
            case (state)
                ST_COLD:
                begin
                    state <= ST_WAIT_READY;
                end
                ST_WAIT_READY:
                begin
                    if (pll_ok && nvram_ok)
                    begin
                        state <= ST_HOLD;
                        cnt <= '0;
                    end
                end
                ST_HOLD, ST_WARM_HOLD:
                begin
                    if (cnt == CNT_BITS'(HOLD_CYCLES - 1))
                    begin
                        state <= (state == ST_HOLD) ? ST_SAMPLE_WAIT : ST_WARM_WAIT;
                        cnt <= '0;
                    end
                    else
                    begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_SAMPLE_WAIT, ST_WARM_WAIT:
                begin
                    if (cnt >= CNT_BITS'(SAMPLE_WAIT_CYCLES - 1))
                    begin
                        if (warm_n)
                        begin
                            state <= (state == ST_SAMPLE_WAIT) ? ST_RUN : ST_CS_WAIT;
                            cnt <= '0;
                        end
                    end
                    else
                    begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_CS_WAIT:
                begin
                    if (cnt == CNT_BITS'(CS_DELAY_CYCLES - 1))
                    begin
                        state <= ST_RUN;
                    end
                    else
                    begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (!warm_n)
                    begin
                        state <= ST_WARM_HOLD;
                        cnt <= '0;
                    end
                end
                default:
                begin
                    state <= ST_COLD;
                end
            endcase
        end
    end

    // low address comes back within a few cycles of release
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            drive_cnt <= '0;
        end
        else if (!cold_n)
        begin
            drive_cnt <= '0;
        end
        else if (drive_cnt != 5'(VEC_TAP))
        begin
            drive_cnt <= drive_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            reset_exception_o <= 1'b0;
            soft_reset_exception_o <= 1'b0;
            mem_periph_addr_lo_o <= ADDR_LO_RESET;
            mem_periph_addr_hi_o <= ADDR_HI_RESET;
        end
        else
        begin
            reset_exception_o <= (state == ST_SAMPLE_WAIT) && warm_n
                && (cnt >= CNT_BITS'(SAMPLE_WAIT_CYCLES - 1));
            soft_reset_exception_o <= (state == ST_CS_WAIT)
                && (cnt == CNT_BITS'(CS_DELAY_CYCLES - 1));
            mem_periph_addr_lo_o <= addr_lo_req_i;
            mem_periph_addr_hi_o <= addr_hi_req_i;
        end
    end

    // ----------------------------------------------------------------
    // pin enables
    // ----------------------------------------------------------------
    logic line_drive;
    assign line_drive = !cold_reset_n_in_i || (state == ST_COLD) || (state == ST_WAIT_READY)
        || (state == ST_HOLD) || (state == ST_WARM_HOLD);

    assign warm_reset_n_io_o = 1'b0;
    assign warm_reset_n_io_oe_n_o = !line_drive;
    // float is combinational from the raw pin so it is immediate
    assign mem_periph_addr_lo_oe_n_o = !cold_reset_n_in_i || !cold_n
        || (drive_cnt != 5'(VEC_TAP));
    assign mem_periph_data_oe_n_o = (state != ST_RUN);
    assign mem_ctrl_enable_o = (state == ST_RUN) && warm_n;
    assign chip_select_enable_o = (state == ST_RUN);
    assign ext_bus_clock_en_o = (state == ST_HOLD) || (state == ST_SAMPLE_WAIT)
        || (state == ST_RUN) || (state == ST_WARM_HOLD) || (state == ST_WARM_WAIT)
        || (state == ST_CS_WAIT);
endmodule
`default_nettype wire

/* File: src/reset_seq_pkg.sv */
// constants for the cold and warm reset sequencer
`default_nettype none
package reset_seq_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int HOLD_CYCLES = 4000;
    localparam int SAMPLE_WAIT_CYCLES = 4000;
    localparam int DRIVE_RESUME_MAX_CYCLES = 16;
    localparam int CS_DELAY_CYCLES = 16;
    localparam int VEC_TAP = 2;
    localparam int PLL_CNT_BITS = 18;
    localparam int CNT_BITS = 18;
    localparam int ADDR_LO_W = 16;
    localparam int ADDR_HI_W = 6;
    localparam int DATA_W = 8;
    localparam int CS_W = 4;
    localparam int PCLK_SEL_W = 3;
    localparam int PCLK_SEL_LSB = 0;
    localparam int NVRAM_DIS_BIT = 3;
    localparam logic [ADDR_HI_W-1:0] ADDR_HI_RESET = 6'h00;
    localparam logic [ADDR_LO_W-1:0] ADDR_LO_RESET = 16'h0000;
    typedef enum logic [2:0] {
        ST_COLD,
        ST_WAIT_READY,
        ST_HOLD,
        ST_SAMPLE_WAIT,
        ST_RUN,
        ST_WARM_HOLD,
        ST_WARM_WAIT,
        ST_CS_WAIT
    } seq_state_t;
endpackage
`default_nettype wire
